// ===== common/dsa_map.svh
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define DSA_IDX_LIVE       8'h18
`define DSA_IDX_LATCH      8'h19
`define DSA_IDX_IRQEN      8'h1a
`define DSA_IDX_CTRL       8'h1c

// ==========================================================================
// Field layout
// ==========================================================================
`define DSA_BIT_LOS        0
`define DSA_BIT_OOF        1
`define DSA_BIT_AIS        2
`define DSA_BIT_RAI        3
`define DSA_BIT_IDLE       4
`define DSA_BIT_SEF        5
`define DSA_BIT_COFA       7
`define DSA_NUM_ALARMS     6
`define DSA_LIVE_MASK      8'h3f
`define DSA_LATCH_MASK     8'hbf
`define DSA_CTRL_GIE_BIT   0
`define DSA_CTRL_DUAL_BIT  1
`define DSA_CTRL_MASK      8'h03

// ==========================================================================
// Reset values
// ==========================================================================
`define DSA_LIVE_RST       8'h02
`define DSA_LATCH_RST      8'h00
`define DSA_IRQEN_RST      8'h00
`define DSA_CTRL_RST       8'h00

`endif

// ===== common/dsa_pkg.sv
// ==========================================================================
// Shared types
// ==========================================================================
package dsa_pkg;

    // AXI response codes
    typedef enum logic [1:0] {
        DSA_RESP_OKAY   = 2'b00,
        DSA_RESP_SLVERR = 2'b10
    } dsa_resp_e;

    // One bit per live alarm condition
    typedef logic [5:0] dsa_alarm_t;

endpackage

// ===== hw/dsa_sync2.sv
`timescale 1ns/1ps
// ==========================================================================
// Two-flop synchroniser for asynchronous level inputs
// ==========================================================================
module dsa_sync2 import dsa_pkg::*; #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage2
        logic [WIDTH-1:0] stage2;  // Settled stage
    } dsa_sync_s;

    dsa_sync_s st_reg;
    dsa_sync_s st_next;

    // Shift the level through both stages
    always_comb begin
        st_next        = st_reg;
        st_next.stage1 = async_in;
        st_next.stage2 = st_reg.stage1;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stage2;

endmodule // dsa_sync2

// ===== hw/dsa_axil_slave.sv
`timescale 1ns/1ps
// ==========================================================================
// AXI4-Lite slave front end: one write and one read in flight
// ==========================================================================
module dsa_axil_slave import dsa_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Write address and data channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address and data channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Register file side
    output logic                   wr_fire,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_ok,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_ok
);

    typedef struct packed {
        logic              aw_hold;  // Write address captured
        logic [ADDR_W-1:0] aw_addr;
        logic              w_hold;   // Write data captured
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        dsa_resp_e         bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        dsa_resp_e         rresp;
    } dsa_axil_s;

    dsa_axil_s st_reg;
    dsa_axil_s st_next;

    // Handshakes: a channel is open while its holding slot is empty
    assign awready = !st_reg.aw_hold;
    assign wready  = !st_reg.w_hold;
    assign arready = !st_reg.rvalid;
    // Write commits once both halves are in and the last answer is gone
    assign wr_fire = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
    assign wr_addr = st_reg.aw_addr;
    assign wr_data = st_reg.w_data;
    assign wr_strb = st_reg.w_strb;
    assign rd_addr = araddr;

    // Next state of both channels
    always_comb begin
        st_next = st_reg;
        // Address and data may come in either order
        if (awvalid && !st_reg.aw_hold) begin
            st_next.aw_hold = 1'b1;
            st_next.aw_addr = awaddr;
        end
        if (wvalid && !st_reg.w_hold) begin
            st_next.w_hold = 1'b1;
            st_next.w_data = wdata;
            st_next.w_strb = wstrb;
        end
        if (wr_fire) begin
            st_next.aw_hold = 1'b0;
            st_next.w_hold  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_ok ? DSA_RESP_OKAY : DSA_RESP_SLVERR;
        end else if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        // Read data is sampled in the cycle the address is taken
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end else if (arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_data;
            st_next.rresp  = rd_ok ? DSA_RESP_OKAY : DSA_RESP_SLVERR;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bvalid = st_reg.bvalid;
    assign bresp  = st_reg.bresp;
    assign rvalid = st_reg.rvalid;
    assign rdata  = st_reg.rdata;
    assign rresp  = st_reg.rresp;

endmodule // dsa_axil_slave

// ===== hw/dsa_alarm_irq.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dsa_map.svh"
// Overview of operation
// R1: Live register bit 0 follows loss of signal.
// R2: Loss of signal from LIU in binary mode.
// R3: Live bit 1 follows out-of-frame.
// R4: Live bit 2 follows alarm indication signal.
// R5: Live bit 3: remote alarm, X/Sa bits only.
// R6: Live bit 4 follows DS3 idle signal.
// R7: Live bit 5 follows severely errored frame.
// R8: Latched bits set on any live change.
// R9: Writing one clears latched bit; zero keeps.
// R10: Interrupt when latched, enabled and globally enabled.
// R11: Interrupt drops once latch or enable clears.
// R12: Bit 7 latches resync at new alignment.
// R13: Alignment latch rearms only after sync loss.
// R14: Enable register, one bit each, reset zero.
// R15: Enable bit 7 gates alignment-change interrupt.
// R16: Unused bits read zero, ignore writes.
module dsa_alarm_irq import dsa_pkg::*; #(
    parameter int ADDR_W  = 12,
    parameter int ALIGN_W = 4
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Alarm detector levels from the receive framer
    input  wire logic               los_det,
    input  wire logic               oof_det,
    input  wire logic               ais_det,
    input  wire logic               rai_xsa_det,
    input  wire logic               ds3_idle_det,
    input  wire logic               sef_det,
    // Loss of signal pin from the line interface unit
    input  wire logic               liu_los_pin,
    // Frame synchroniser state
    input  wire logic               sync_acquired,
    input  wire logic [ALIGN_W-1:0] sync_align,
    // Interrupt
    output logic                    irq
);

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        logic [7:0]         live;         // Real-time status
        logic [7:0]         latched;      // Sticky change flags
        logic [7:0]         irq_en;       // Per-bit interrupt enables
        logic [7:0]         ctrl;         // Global enable and line mode
        logic               sync_prev;    // Last sampled sync level
        logic               ever_synced;  // Framer has locked at least once
        logic [ALIGN_W-1:0] align;        // Alignment of the last lock
    } dsa_core_s;

    dsa_core_s st_reg;
    dsa_core_s st_next;

    // Bus side wires
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_ok;

    // Decode and datapath wires
    logic              liu_los_sync;   // Pin after two flops
    logic              wr_live;
    logic              wr_latch;
    logic              wr_irqen;
    logic              wr_ctrl;
    logic [7:0]        wr_byte;        // Low lane only
    logic [7:0]        live_next;      // Value the live register takes
    logic [7:0]        lat_set;        // Hardware set requests
    logic [7:0]        lat_clr;        // Software clear requests
    logic [7:0]        lat_upd;        // New latched value
    logic              cofa_event;     // Relock at a new alignment
    logic              global_en;
    logic              dual_rail;

    // ======================================================================
    // Bus slave and pin synchroniser
    // ======================================================================
    dsa_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk     (clk),
        .nrst    (nrst),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_fire (wr_fire),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // The pin is asynchronous to clk, so it is settled before any use
    dsa_sync2 #(
        .WIDTH (1)
    ) u_los_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (liu_los_pin),
        .sync_out (liu_los_sync)
    );

    // ======================================================================
    // Address decode
    // ======================================================================
    // Word-aligned match of an address against a register index
    function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        idx_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    assign wr_live  = idx_hit(wr_addr, `DSA_IDX_LIVE);
    assign wr_latch = idx_hit(wr_addr, `DSA_IDX_LATCH) && wr_fire && wr_strb[0];
    assign wr_irqen = idx_hit(wr_addr, `DSA_IDX_IRQEN) && wr_fire && wr_strb[0];
    assign wr_ctrl  = idx_hit(wr_addr, `DSA_IDX_CTRL) && wr_fire && wr_strb[0];
    assign wr_byte  = wr_data[7:0];
    // Writes to the live register are accepted and have no effect
    assign wr_ok    = wr_live || idx_hit(wr_addr, `DSA_IDX_LATCH)
                      || idx_hit(wr_addr, `DSA_IDX_IRQEN) || idx_hit(wr_addr, `DSA_IDX_CTRL);

    // Read mux; unmapped words read zero with an error response
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (idx_hit(rd_addr, `DSA_IDX_LIVE)) begin
            rd_data[7:0] = st_reg.live;
        end else if (idx_hit(rd_addr, `DSA_IDX_LATCH)) begin
            rd_data[7:0] = st_reg.latched;
        end else if (idx_hit(rd_addr, `DSA_IDX_IRQEN)) begin
            rd_data[7:0] = st_reg.irq_en;
        end else if (idx_hit(rd_addr, `DSA_IDX_CTRL)) begin
            rd_data[7:0] = st_reg.ctrl;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ======================================================================
    // Live status sources
    // ======================================================================
    assign global_en = st_reg.ctrl[`DSA_CTRL_GIE_BIT];
    assign dual_rail = st_reg.ctrl[`DSA_CTRL_DUAL_BIT];

    // In binary mode the LIU has already decoded zeros, so only it can see LOS
    always_comb begin
        live_next                 = 8'h00;                          // R16
        live_next[`DSA_BIT_LOS]   = dual_rail ? los_det : liu_los_sync; // R1 R2
        live_next[`DSA_BIT_OOF]   = oof_det;                        // R3
        live_next[`DSA_BIT_AIS]   = ais_det;                        // R4
        live_next[`DSA_BIT_RAI]   = rai_xsa_det;                    // R5
        live_next[`DSA_BIT_IDLE]  = ds3_idle_det;                   // R6
        live_next[`DSA_BIT_SEF]   = sef_det;                        // R7
    end

    // Rising sync with a different alignment than the previous lock
    assign cofa_event = sync_acquired && !st_reg.sync_prev && st_reg.ever_synced
                        && (sync_align != st_reg.align); // R12 R13

    // ======================================================================
    // Latched bits, one slice per position
    // ======================================================================
    // Set beats clear so an edge in the clearing cycle is never lost
    // A literal cannot take a bit-select, so the mask is held as a constant
    localparam logic [7:0] LATCH_MASK = `DSA_LATCH_MASK; // Implemented latch positions
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_latch
            if (gi < `DSA_NUM_ALARMS) begin : g_alarm
                assign lat_set[gi] = live_next[gi] ^ st_reg.live[gi]; // R8
            end else if (gi == `DSA_BIT_COFA) begin : g_cofa
                assign lat_set[gi] = cofa_event; // R12
            end else begin : g_unused
                assign lat_set[gi] = 1'b0; // R16
            end
            assign lat_clr[gi] = wr_latch && wr_byte[gi]; // R9
            assign lat_upd[gi] = LATCH_MASK[gi]
                                 && (lat_set[gi] || (st_reg.latched[gi] && !lat_clr[gi]));
        end
    endgenerate

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        st_next         = st_reg;
        st_next.live    = live_next;
        st_next.latched = lat_upd;
        // Enables keep only implemented positions
        if (wr_irqen) begin
            st_next.irq_en = wr_byte & `DSA_LATCH_MASK; // R14 R15 R16
        end
        if (wr_ctrl) begin
            st_next.ctrl = wr_byte & `DSA_CTRL_MASK;
        end
        // Track lock history for alignment comparison
        st_next.sync_prev = sync_acquired;
        if (sync_acquired && !st_reg.sync_prev) begin
            st_next.ever_synced = 1'b1;
            st_next.align       = sync_align; // R13
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg.live        <= `DSA_LIVE_RST;
            st_reg.latched     <= `DSA_LATCH_RST;
            st_reg.irq_en      <= `DSA_IRQEN_RST; // R14
            st_reg.ctrl        <= `DSA_CTRL_RST;
            st_reg.sync_prev   <= 1'b0;
            st_reg.ever_synced <= 1'b0;
            st_reg.align       <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Level interrupt straight from flops, so it drops the cycle after a clear
    assign irq = global_en && |(st_reg.latched & st_reg.irq_en); // R10 R11 R15

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_los_dual;
        dual_rail |=> (st_reg.live[0] == $past(los_det));
    endproperty
    a_los_dual: assert property (p_los_dual) else $error("los live bit wrong in dual rail"); // R1

    property p_los_binary;
        !dual_rail |=> (st_reg.live[0] == $past(liu_los_sync));
    endproperty
    a_los_binary: assert property (p_los_binary) else $error("los not from pin in binary"); // R2

    property p_oof_live;
        oof_det ##1 oof_det |=> st_reg.live[1];
    endproperty
    a_oof_live: assert property (p_oof_live) else $error("oof live bit not high"); // R3

    property p_ais_live;
        $fell(ais_det) |=> !st_reg.live[2];
    endproperty
    a_ais_live: assert property (p_ais_live) else $error("ais live bit stuck"); // R4

    property p_rai_live;
        (st_reg.live[3] == $past(rai_xsa_det));
    endproperty
    a_rai_live: assert property (p_rai_live) else $error("rai live bit mismatch"); // R5

    property p_idle_sef_live;
        (st_reg.live[5:4] == $past({sef_det, ds3_idle_det}));
    endproperty
    a_idle_sef_live: assert property (p_idle_sef_live) else $error("idle or sef bit wrong"); // R6 R7

    property p_latch_on_change;
        ((st_reg.live ^ $past(st_reg.live)) & st_reg.latched) == (st_reg.live ^ $past(st_reg.live));
    endproperty
    a_latch_on_change: assert property (p_latch_on_change) else $error("change not latched"); // R8

    property p_w1c;
        wr_latch |=> ((st_reg.latched & $past(wr_byte & ~lat_set)) == 8'h00)
                     && ((st_reg.latched & ~$past(wr_byte)) == ($past(st_reg.latched | lat_set)
                         & ~$past(wr_byte) & `DSA_LATCH_MASK));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one clear misbehaved"); // R9

    property p_irq_raise;
        global_en && (st_reg.latched[2] && st_reg.irq_en[2]) |-> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("irq missing"); // R10

    property p_irq_global_off;
        wr_ctrl && !wr_byte[0] |=> !irq;
    endproperty
    a_irq_global_off: assert property (p_irq_global_off) else $error("irq after global off"); // R11

    property p_cofa_set;
        sync_acquired && !st_reg.sync_prev && st_reg.ever_synced
            && (sync_align != st_reg.align) |=> st_reg.latched[7];
    endproperty
    a_cofa_set: assert property (p_cofa_set) else $error("alignment change not latched"); // R12

    property p_cofa_cause;
        $rose(st_reg.latched[7]) |-> $past(cofa_event);
    endproperty
    a_cofa_cause: assert property (p_cofa_cause) else $error("alignment latch without relock"); // R13

    property p_irqen_write;
        wr_irqen |=> (st_reg.irq_en == ($past(wr_byte) & 8'hbf));
    endproperty
    a_irqen_write: assert property (p_irqen_write) else $error("enable write wrong"); // R14

    property p_cofa_gate;
        (st_reg.latched[7] && !st_reg.irq_en[7] && ((st_reg.latched & st_reg.irq_en) == 8'h00))
            |-> !irq;
    endproperty
    a_cofa_gate: assert property (p_cofa_gate) else $error("ungated alignment irq"); // R15

    property p_reserved;
        (st_reg.live[7:6] == 2'h0) && !st_reg.latched[6] && !st_reg.irq_en[6];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R16

    // Main scenarios
    c_irq_rise:  cover property ($rose(irq));
    c_w1c:       cover property (wr_latch ##1 (st_reg.latched == 8'h00));
    c_cofa:      cover property ($rose(st_reg.latched[7]));
    c_binary_los: cover property (!dual_rail && $rose(st_reg.live[0]));

endmodule // dsa_alarm_irq

// ===== bench/dsa_liu_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Line interface stand-in: owns the loss-of-signal pin in binary mode
// ==========================================================================
module dsa_liu_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Bench request and the pin it drives
    input  wire logic los_req,
    output logic      liu_los_pin
);
    // Pin moves on a clock edge, so the block's synchroniser sees clean levels
    always_ff @(posedge clk or negedge nrst)
        if (!nrst) liu_los_pin <= 1'b0;
        else liu_los_pin <= los_req;
endmodule // dsa_liu_model

// ===== bench/dsa_alarm_irq_tb.sv
`timescale 1ns/1ps
module dsa_alarm_irq_tb import dsa_pkg::*;;
// ==========================================================================
// Signals
// ==========================================================================
localparam logic [11:0] LV = 12'h060, LT = 12'h064, IE = 12'h068, CT = 12'h070;
logic clk = 0, nrst = 0, los_req = 0, irq, sync_acquired = 0;
logic [3:0] sync_align = 0, s_axi_wstrb = 4'hf;
logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
logic [1:0] s_axi_bresp, s_axi_rresp, rr;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, liu_los_pin;
logic los_det = 0, oof_det = 0, ais_det = 0, rai_xsa_det = 0, ds3_idle_det = 0;
logic sef_det = 0;
int num_errors = 0, tests_run = 0, cyc = 0;
dsa_alarm_irq dut (.*);
dsa_liu_model liu (.clk, .nrst, .los_req, .liu_los_pin);
initial forever #2 clk = ~clk;
// ==========================================================================
// Tasks
// ==========================================================================
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        num_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// Address and data offered together, each dropped once its own ready is seen
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
endtask
task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 0;
endtask
task automatic det(input logic [5:0] v);
    @(posedge clk);
    {sef_det, ds3_idle_det, rai_xsa_det, ais_det, oof_det, los_det} <= v;
    repeat (4) @(posedge clk);
endtask
// Framer loses lock, then regains it at the given alignment
task automatic lock(input logic [3:0] a);
    @(posedge clk); sync_acquired <= 0;
    repeat (2) @(posedge clk); sync_align <= a; sync_acquired <= 1;
    repeat (3) @(posedge clk);
endtask
task automatic complete_run;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
// Hang guard: the sequence needs well under a thousand cycles
always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; complete_run; end
end
// ==========================================================================
// Sequence
// ==========================================================================
initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    repeat (3) @(posedge clk);
    rd(LT); chk(rv, 32'h02);
    rd(IE); chk(rv, 32'h00);
    wr(LT, 8'hff); rd(LT); chk(rv, 32'h00);
    wr(IE, 8'hff); rd(IE); chk(rv, 32'hbf);
    wr(CT, 8'h03);
    // Walk each live condition in dual-rail mode, one bit at a time
    for (int i = 0; i < 6; i++) begin
        det(6'(1 << i)); rd(LV); chk(rv, 32'(1 << i));
    end
    det(0); rd(LT); chk(rv, 32'h3f);
    chk({31'h0, irq}, 32'h1);
    wr(IE, 8'h80); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h0);
    wr(IE, 8'hbf); wr(LT, 8'h1f); rd(LT); chk(rv, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(LT, 8'h20); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h0);
    // Binary mode: the detector is ignored, the pin decides
    wr(CT, 8'h01); det(6'h01); rd(LV); chk(rv, 32'h00);
    los_req <= 1; det(6'h01); rd(LV); chk(rv, 32'h01);
    los_req <= 0; det(0); wr(LT, 8'hff);
    lock(4'h3); rd(LT); chk(rv, 32'h00);
    lock(4'h5); rd(LT); chk(rv, 32'h80);
    chk({31'h0, irq}, 32'h1);
    wr(CT, 8'h00); chk({31'h0, irq}, 32'h0);
    rd(CT); chk(rv, 32'h00);
    wr(LT, 8'h80); lock(4'h5); rd(LT); chk(rv, 32'h00);
    rd(12'h07c); chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, DSA_RESP_SLVERR});
    complete_run;
end
endmodule // dsa_alarm_irq_tb
